// ==== core/aprar_defines.svh ====
/*
 * Pointer values, field positions, masks and reset values of the
 * pointer, result and alert register block.
 * Assumes inclusion by bare name from core/ sources only.
 */
`ifndef APRAR_DEFINES_SVH
`define APRAR_DEFINES_SVH

// ****************************************************************
// Pointer values (register select)
// ****************************************************************
`define APRAR_PTR_RESULT  3'h0
`define APRAR_PTR_STATUS  3'h1
`define APRAR_PTR_CONFIG  3'h2
`define APRAR_PTR_LOW     3'h3
`define APRAR_PTR_HIGH    3'h4
`define APRAR_PTR_HYST    3'h5
`define APRAR_PTR_LOWEST  3'h6
`define APRAR_PTR_HIGHEST 3'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define APRAR_FLD_MSB       11
`define APRAR_FLD_LSB       2
`define APRAR_RES_ALERT_BIT 15
`define APRAR_ST_OVER_BIT   1
`define APRAR_ST_UNDER_BIT  0
`define APRAR_CFG_HOLD_BIT  4
`define APRAR_CFG_FLAG_BIT  3
`define APRAR_CFG_WMASK     8'hfd

// ****************************************************************
// Reset values
// ****************************************************************
`define APRAR_PTR_RST     8'h00
`define APRAR_RESULT_RST  16'h0000
`define APRAR_CONFIG_RST  8'h00
`define APRAR_LOW_RST     16'h0000
`define APRAR_HIGH_RST    16'h0fff
`define APRAR_HYST_RST    16'h0000
`define APRAR_LOWEST_RST  16'h0ffc
`define APRAR_HIGHEST_RST 16'h0000

`endif

// ==== core/aprar_pkg.sv ====
/*
 * State types of the pointer, result and alert register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package aprar_pkg;

    // ************************************************************
    // Register-side state (clk domain)
    // ************************************************************
    typedef struct packed {
        logic [7:0]  ptr;
        logic        byte_hi;
        logic [7:0]  hi_byte;
        logic [9:0]  result;
        logic [7:0]  cfg;
        logic [9:0]  low_lim;
        logic [9:0]  high_lim;
        logic [9:0]  hyst;
        logic [9:0]  lowest;
        logic [9:0]  highest;
        logic [15:0] rsp_word;
        logic        ack_tgl;
        logic        req_seen;
        logic        conv_req;
    } aprar_core_t;

    // ************************************************************
    // Link-side state (link_clk domain)
    // ************************************************************
    typedef struct packed {
        logic        req_tgl;
        logic        is_rd;
        logic        first;
        logic [7:0]  wbyte;
        logic        busy;
        logic        ack_seen;
        logic        rd_valid;
        logic [15:0] rd_word;
    } aprar_link_t;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } aprar_sync_t;

endpackage : aprar_pkg

// ==== core/aprar_sync.sv ====
/*
 * Two-flop level synchroniser.
 * Assumes d is a level from another clock domain, held for at least
 * two destination clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module aprar_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);

    aprar_pkg::aprar_sync_t s_q;
    aprar_pkg::aprar_sync_t s_d;

    // First stage feeds only the second stage
    always_comb begin
        s_d        = s_q;
        s_d.stage1 = d;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.stage2;

endmodule : aprar_sync

`default_nettype wire

// ==== core/aprar_alert_flag.sv ====
/*
 * One sticky alert flag with self-clear and write-one-to-clear.
 * Assumes set, auto_clr and w1c are single-cycle terms on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module aprar_alert_flag (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic set_evt,
    input  wire logic auto_clr,
    input  wire logic w1c,
    output logic      flag
);

    typedef struct packed {
        logic flag;
    } aprar_flag_t;

    aprar_flag_t f_q;
    aprar_flag_t f_d;

    // Set beats any clear landing in the same cycle
    always_comb begin
        f_d      = f_q;
        f_d.flag = set_evt | (f_q.flag & ~auto_clr & ~w1c);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    assign flag = f_q.flag;

endmodule : aprar_alert_flag

`default_nettype wire

// ==== core/aprar_regs.sv ====
/*
 * Pointer, conversion result and alert status register block.
 * The serial controller front end delivers whole bytes on link_clk;
 * the converter delivers finished codes on clk. Link resets on
 * link_rst, register side on sys_rst.
 * Both resets must overlap, or a request toggle can be lost.
 */
// Functional notes
// - First write byte loads the pointer.
// - Later bytes and reads use the pointer.
// - Only pointer bits 2:0 are decoded.
// - Pointer resets to zero, result selected.
// - Pointer values 0..7 map fixed register order.
// - Result register ignores writes.
// - Code in bits 11:2, others zero.
// - Bit 15 is flags OR when enabled.
// - Status is 8-bit, read and write.
// - Status bits 7:2 read zero.
// - Over flag sets above upper limit.
// - Over flag self-clears below limit minus hysteresis.
// - Writing one clears over flag; hold keeps.
// - Under flag sets below lower limit.
// - Under flag self-clears above limit plus hysteresis.
// - Writing one clears under flag; hold keeps.
// - Config bit 4 is alert hold.
// - Config bit 3 enables result bit 15.
`timescale 1ns/1ps
`default_nettype none
`include "aprar_defines.svh"

module aprar_regs (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        link_clk,
    input  wire logic        link_rst,
    input  wire logic        link_wr_stb,
    input  wire logic        link_wr_first,
    input  wire logic [7:0]  link_wr_byte,
    input  wire logic        link_rd_stb,
    output logic             link_busy,
    output logic             link_rd_valid,
    output logic [15:0]      link_rd_word,
    input  wire logic        conv_valid,
    input  wire logic [9:0]  conv_code,
    output logic             conv_req,
    output logic             alert_over,
    output logic             alert_under
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] fld_word(input logic [9:0] v);
        fld_word = {4'h0, v, 2'h0};
    endfunction : fld_word

    // Reserved bits of a written word are dropped
    function automatic logic [9:0] word_fld(input logic [15:0] w);
        word_fld = w[`APRAR_FLD_MSB:`APRAR_FLD_LSB];
    endfunction : word_fld

    // Sums kept one bit wider so hysteresis never wraps
    function automatic logic [10:0] wide_sum(input logic [9:0] a,
                                             input logic [9:0] b);
        wide_sum = {1'b0, a} + {1'b0, b};
    endfunction : wide_sum

    // Status and config take one data byte, the rest take two
    function automatic logic is_wide(input logic [2:0] sel);
        is_wide = !(sel == `APRAR_PTR_STATUS ||
                    sel == `APRAR_PTR_CONFIG);
    endfunction : is_wide

    // ************************************************************
    // State
    // ************************************************************
    aprar_pkg::aprar_core_t c_q;
    aprar_pkg::aprar_core_t c_d;
    aprar_pkg::aprar_link_t l_q;
    aprar_pkg::aprar_link_t l_d;

    // Named terms of the crossings, flag cells and read path
    logic        req_s;
    logic        ack_s;
    logic        req_evt;
    logic [2:0]  sel;
    logic [15:0] wword;
    logic        wr_status;
    logic        flag_over;
    logic        flag_under;
    logic        hold;
    logic        over_set;
    logic        over_auto;
    logic        under_set;
    logic        under_auto;
    logic [10:0] over_sum;
    logic [10:0] under_sum;
    logic [15:0] rd_mux;

    // ************************************************************
    // Domain crossings
    // ************************************************************
    // Byte, kind and first flag stay frozen in l_q while busy, so
    // only the toggle needs synchronising; same for rsp_word back.
    // Trade-off: one request per round trip, a few cycles a byte,
    // in return for no word crossing ungated.
    aprar_sync u_req_sync (
        .clk (clk),
        .rst (sys_rst),
        .d   (l_q.req_tgl),
        .q   (req_s)
    );

    aprar_sync u_ack_sync (
        .clk (link_clk),
        .rst (link_rst),
        .d   (c_q.ack_tgl),
        .q   (ack_s)
    );

    // ************************************************************
    // Link side: one byte or read request in flight at a time
    // ************************************************************
    always_comb begin
        l_d          = l_q;
        l_d.rd_valid = 1'b0;
        if (l_q.busy) begin
            if (ack_s != l_q.ack_seen) begin
                l_d.busy     = 1'b0;
                l_d.ack_seen = ack_s;
                if (l_q.is_rd) begin
                    l_d.rd_valid = 1'b1;
                    l_d.rd_word  = c_q.rsp_word;
                end
            end
        end else if (link_wr_stb || link_rd_stb) begin
            // Write wins if both strobes arrive together
            // Later strobes are dropped until the answer returns
            l_d.busy    = 1'b1;
            l_d.req_tgl = ~l_q.req_tgl;
            l_d.is_rd   = ~link_wr_stb;
            l_d.first   = link_wr_first;
            l_d.wbyte   = link_wr_byte;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // ************************************************************
    // Alert compare terms
    // ************************************************************
    // Hold only gates self-clear; writing a one still clears
    assign hold = c_q.cfg[`APRAR_CFG_HOLD_BIT];

    // Strict compares: a code right at the margin keeps its flag
    assign over_sum  = wide_sum(conv_code, c_q.hyst);
    assign under_sum = wide_sum(c_q.low_lim, c_q.hyst);

    assign over_set   = conv_valid && (conv_code > c_q.high_lim);
    assign over_auto  = conv_valid && !hold &&
                        (over_sum < {1'b0, c_q.high_lim});
    assign under_set  = conv_valid && (conv_code < c_q.low_lim);
    assign under_auto = conv_valid && !hold &&
                        ({1'b0, conv_code} > under_sum);

    aprar_alert_flag u_over (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .set_evt  (over_set),
        .auto_clr (over_auto),
        .w1c      (wr_status &
                   c_q.hi_byte[`APRAR_ST_OVER_BIT]),
        .flag     (flag_over)
    );

    aprar_alert_flag u_under (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .set_evt  (under_set),
        .auto_clr (under_auto),
        .w1c      (wr_status &
                   c_q.hi_byte[`APRAR_ST_UNDER_BIT]),
        .flag     (flag_under)
    );

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    assign sel = c_q.ptr[2:0];

    always_comb begin
        unique case (sel)
            `APRAR_PTR_RESULT: begin
                rd_mux = fld_word(c_q.result);
                // Summary bit follows the enable, not the hold setting
                rd_mux[`APRAR_RES_ALERT_BIT] =
                    c_q.cfg[`APRAR_CFG_FLAG_BIT] &
                    (flag_over | flag_under);
            end
            `APRAR_PTR_STATUS: begin
                rd_mux = {14'h0000, flag_over, flag_under};
            end
            `APRAR_PTR_CONFIG: begin
                rd_mux = {8'h00, c_q.cfg};
            end
            `APRAR_PTR_LOW: begin
                rd_mux = fld_word(c_q.low_lim);
            end
            `APRAR_PTR_HIGH: begin
                rd_mux = fld_word(c_q.high_lim);
            end
            `APRAR_PTR_HYST: begin
                rd_mux = fld_word(c_q.hyst);
            end
            `APRAR_PTR_LOWEST: begin
                rd_mux = fld_word(c_q.lowest);
            end
            `APRAR_PTR_HIGHEST: begin
                rd_mux = fld_word(c_q.highest);
            end
        endcase
    end

    // ************************************************************
    // Register side
    // ************************************************************
    assign req_evt = (req_s != c_q.req_seen);
    assign wword   = {c_q.hi_byte, l_q.wbyte};

    always_comb begin
        c_d          = c_q;
        c_d.conv_req = 1'b0;
        if (req_evt) begin
            c_d.req_seen = req_s;
            c_d.ack_tgl  = ~c_q.ack_tgl;
            if (l_q.is_rd) begin
                c_d.rsp_word = rd_mux;
                // Reading the result starts the next conversion
                c_d.conv_req = (sel == `APRAR_PTR_RESULT);
            end else if (l_q.first) begin
                c_d.ptr     = l_q.wbyte;
                c_d.byte_hi = 1'b0;
            end else if (!is_wide(sel)) begin
                if (sel == `APRAR_PTR_STATUS) begin
                    // Byte parked in hi_byte for the flag clears
                    c_d.hi_byte = l_q.wbyte;
                end else begin
                    c_d.cfg = l_q.wbyte & `APRAR_CFG_WMASK;
                end
            end else if (!c_q.byte_hi) begin
                // High byte waits; the pair lands on the low byte
                c_d.hi_byte = l_q.wbyte;
                c_d.byte_hi = 1'b1;
            end else begin
                c_d.byte_hi = 1'b0;
                unique case (sel)
                    `APRAR_PTR_RESULT: begin
                        // Read-only: the pair is dropped here
                    end
                    `APRAR_PTR_LOW: begin
                        c_d.low_lim = word_fld(wword);
                    end
                    `APRAR_PTR_HIGH: begin
                        c_d.high_lim = word_fld(wword);
                    end
                    `APRAR_PTR_HYST: begin
                        c_d.hyst = word_fld(wword);
                    end
                    `APRAR_PTR_LOWEST: begin
                        c_d.lowest = word_fld(wword);
                    end
                    `APRAR_PTR_HIGHEST: begin
                        c_d.highest = word_fld(wword);
                    end
                    // Status and config never reach this branch
                    default: ;
                endcase
            end
        end
        if (conv_valid) begin
            // Min and max compare against a write landing in the same cycle
            c_d.result = conv_code;
            if (conv_code < c_d.lowest) begin
                c_d.lowest = conv_code;
            end
            if (conv_code > c_d.highest) begin
                c_d.highest = conv_code;
            end
        end
    end

    // ************************************************************
    // Register update
    // ************************************************************
    // Status write pulses one cycle after the byte is parked
    logic wr_status_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            c_q.ptr      <= `APRAR_PTR_RST;
            c_q.byte_hi  <= 1'b0;
            c_q.hi_byte  <= 8'h00;
            c_q.result   <= word_fld(`APRAR_RESULT_RST);
            c_q.cfg      <= `APRAR_CONFIG_RST;
            c_q.low_lim  <= word_fld(`APRAR_LOW_RST);
            c_q.high_lim <= word_fld(`APRAR_HIGH_RST);
            c_q.hyst     <= word_fld(`APRAR_HYST_RST);
            c_q.lowest   <= word_fld(`APRAR_LOWEST_RST);
            c_q.highest  <= word_fld(`APRAR_HIGHEST_RST);
            c_q.rsp_word <= 16'h0000;
            c_q.ack_tgl  <= 1'b0;
            c_q.req_seen <= 1'b0;
            c_q.conv_req <= 1'b0;
            wr_status_q  <= 1'b0;
        end else begin
            c_q          <= c_d;
            wr_status_q  <= req_evt && !l_q.is_rd && !l_q.first &&
                            (sel == `APRAR_PTR_STATUS);
        end
    end

    assign wr_status = wr_status_q;

    // ************************************************************
    // Outputs
    // ************************************************************
    // Each output leaves straight from a flop here or in a flag cell
    assign link_busy     = l_q.busy;
    assign link_rd_valid = l_q.rd_valid;
    assign link_rd_word  = l_q.rd_word;
    assign conv_req      = c_q.conv_req;
    assign alert_over    = flag_over;
    assign alert_under   = flag_under;

endmodule : aprar_regs

`default_nettype wire

// ==== bench/aprar_regs_sva.sv ====
/* Port checker of the register block.
   Assumes it is bound to aprar_regs. */
`timescale 1ns/1ps
`default_nettype none
module aprar_regs_sva (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        link_clk,
    input wire logic        link_rst,
    input wire logic        link_wr_stb,
    input wire logic        link_wr_first,
    input wire logic [7:0]  link_wr_byte,
    input wire logic        link_rd_stb,
    input wire logic        link_busy,
    input wire logic        link_rd_valid,
    input wire logic [15:0] link_rd_word,
    input wire logic        conv_valid,
    input wire logic [9:0]  conv_code,
    input wire logic        conv_req,
    input wire logic        alert_over,
    input wire logic        alert_under
);
    // ****************************************************
    // Link side
    // ****************************************************
    a_busy_take: assert property (@(posedge link_clk)
        disable iff (link_rst)
        !link_busy && (link_wr_stb || link_rd_stb) |=> link_busy)
        else $error("busy did not follow a strobe");
    a_busy_bound: assert property (@(posedge link_clk)
        disable iff (link_rst) $rose(link_busy) |-> ##[1:10] !link_busy)
        else $error("busy held too long");
    a_rdv_fall: assert property (@(posedge link_clk)
        disable iff (link_rst) link_rd_valid |-> $fell(link_busy))
        else $error("read valid apart from busy fall");
    a_rdv_pulse: assert property (@(posedge link_clk)
        disable iff (link_rst) link_rd_valid |=> !link_rd_valid)
        else $error("read valid longer than one cycle");
    a_word_hold: assert property (@(posedge link_clk)
        disable iff (link_rst) $changed(link_rd_word) |-> link_rd_valid)
        else $error("read word moved without an answer");
    // ****************************************************
    // Register side
    // ****************************************************
    a_req_pulse: assert property (@(posedge clk)
        disable iff (sys_rst) conv_req |=> !conv_req)
        else $error("conversion request longer than one cycle");
    a_over_cause: assert property (@(posedge clk)
        disable iff (sys_rst) $rose(alert_over) |-> $past(conv_valid))
        else $error("over flag set without a conversion");
    a_under_cause: assert property (@(posedge clk)
        disable iff (sys_rst) $rose(alert_under) |-> $past(conv_valid))
        else $error("under flag set without a conversion");
    c_read: cover property (@(posedge link_clk) link_rd_valid);
    c_over: cover property (@(posedge clk) $rose(alert_over));
    c_req: cover property (@(posedge clk) conv_req);
endmodule : aprar_regs_sva
bind aprar_regs aprar_regs_sva u_sva (
    .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .link_rst(link_rst), .link_wr_stb(link_wr_stb),
    .link_wr_first(link_wr_first), .link_wr_byte(link_wr_byte),
    .link_rd_stb(link_rd_stb), .link_busy(link_busy),
    .link_rd_valid(link_rd_valid), .link_rd_word(link_rd_word),
    .conv_valid(conv_valid), .conv_code(conv_code),
    .conv_req(conv_req), .alert_over(alert_over),
    .alert_under(alert_under));
`default_nettype wire

// ==== bench/aprar_ctrl_model.sv ====
/* Serial controller byte front end: offers bytes and reads.
   Assumes link_clk runs and the block is out of reset. */
`timescale 1ns/1ps
`default_nettype none
module aprar_ctrl_model (
    input  wire logic        link_clk,
    input  wire logic        link_busy,
    input  wire logic [15:0] link_rd_word,
    output logic             link_wr_stb,
    output logic             link_wr_first,
    output logic [7:0]       link_wr_byte,
    output logic             link_rd_stb
);
    // ****************************************************
    // Transfer
    // ****************************************************
    int n_hang = 0;
    initial begin
        link_wr_stb   = 1'b0;
        link_wr_first = 1'b0;
        link_wr_byte  = 8'h00;
        link_rd_stb   = 1'b0;
    end
    // Pointer upper bits and status 7:2 are sent as zero by callers
    task automatic xfer(input logic rd, input logic f,
                        input logic [7:0] b, input int gap,
                        output logic [15:0] w);
        int n;
        n = 0;
        repeat (gap) @(posedge link_clk);
        @(posedge link_clk);
        link_rd_stb   <= rd;
        link_wr_stb   <= !rd;
        link_wr_first <= f;
        link_wr_byte  <= b;
        @(posedge link_clk);
        link_rd_stb   <= 1'b0;
        link_wr_stb   <= 1'b0;
        // Released lines must not keep a stale copy
        link_wr_first <= ~f;
        link_wr_byte  <= ~b;
        do begin
            @(posedge link_clk);
            n++;
        end while (link_busy !== 1'b0 && n < 12);
        if (n >= 12) n_hang++;
        w = link_rd_word;
    endtask : xfer
endmodule : aprar_ctrl_model
`default_nettype wire

// ==== bench/aprar_regs_tb.sv ====
/* Self-checking bench of the register block.
   Assumes design, checker and controller model compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
    n_mismatch++; $display("ERROR %s exp %h seen %h", n, e, a); end end
module aprar_regs_tb;
    logic        clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        link_rst = 1'b1;
    logic        conv_valid = 1'b0;
    logic [9:0]  conv_code = 10'h000;
    logic        link_wr_stb, link_wr_first, link_rd_stb, link_busy;
    logic        link_rd_valid, conv_req, alert_over, alert_under;
    logic [7:0]  link_wr_byte;
    logic [15:0] link_rd_word, w;
    int          n_mismatch = 0;
    int          compares = 0;
    int          gap = 0;
    int          n_req = 0;
    int          n_rdv = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (conv_req === 1'b1) n_req++;
    always @(posedge link_clk) if (link_rd_valid === 1'b1) n_rdv++;
    always #16 link_clk = ~link_clk;
    aprar_regs u_dut (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .link_rst(link_rst), .link_wr_stb(link_wr_stb),
        .link_wr_first(link_wr_first), .link_wr_byte(link_wr_byte),
        .link_rd_stb(link_rd_stb), .link_busy(link_busy),
        .link_rd_valid(link_rd_valid), .link_rd_word(link_rd_word),
        .conv_valid(conv_valid), .conv_code(conv_code),
        .conv_req(conv_req), .alert_over(alert_over),
        .alert_under(alert_under));
    aprar_ctrl_model m (.link_clk(link_clk), .link_busy(link_busy),
        .link_rd_word(link_rd_word), .link_wr_stb(link_wr_stb),
        .link_wr_first(link_wr_first), .link_wr_byte(link_wr_byte),
        .link_rd_stb(link_rd_stb));
    // ****************************************************
    // Drivers
    // ****************************************************
    task automatic put(input logic f, input logic [7:0] b);
        logic [15:0] x;
        m.xfer(1'b0, f, b, gap, x);
    endtask : put
    task automatic get(input logic [7:0] p, output logic [15:0] v);
        put(1'b1, p);
        m.xfer(1'b1, 1'b0, 8'h00, gap, v);
    endtask : get
    task automatic set8(input logic [7:0] p, input logic [7:0] v);
        put(1'b1, p);
        put(1'b0, v);
    endtask : set8
    task automatic set16(input logic [7:0] p, input logic [15:0] v);
        put(1'b1, p);
        put(1'b0, v[15:8]);
        put(1'b0, v[7:0]);
    endtask : set16
    task automatic conv(input logic [9:0] c);
        @(posedge clk);
        conv_valid <= 1'b1;
        conv_code  <= c;
        @(posedge clk);
        conv_valid <= 1'b0;
        conv_code  <= ~c;
        // Flags settle before callers look
        @(negedge clk);
    endtask : conv
    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_reset;
        // No pointer byte: the reset pointer must pick the result
        m.xfer(1'b1, 1'b0, 8'h00, gap, w);
        @(negedge link_clk);
        `CHK("reset result", 16'h0000, w)
        `CHK("result read pulse", 1, n_req)
        `CHK("read valid pulse", 1, n_rdv)
    endtask : t_reset
    task automatic t_result;
        conv(10'h2a5);
        get(8'h00, w);
        `CHK("result", 16'h0a94, w)
        set16(8'h00, 16'hffff);
        get(8'h00, w);
        `CHK("result kept", 16'h0a94, w)
    endtask : t_result
    task automatic t_ptr;
        logic [7:0]  p [4] = '{8'h03, 8'h04, 8'h05, 8'h02};
        logic [15:0] v [4] = '{16'h0100, 16'h0800, 16'h0040, 16'h0008};
        // Slow controller here, prompt elsewhere
        gap = 2;
        for (int i = 0; i < 4; i++) begin
            if (p[i] == 8'h02) set8(p[i], v[i][7:0]);
            else set16(p[i], v[i]);
            get(p[i], w);
            `CHK("readback", v[i], w)
        end
        gap = 0;
    endtask : t_ptr
    task automatic t_over;
        conv(10'h201);
        `CHK("over set", 1'b1, alert_over)
        get(8'h00, w);
        `CHK("summary bit", 16'h8804, w)
        get(8'h01, w);
        `CHK("status", 16'h0002, w)
        conv(10'h1f0);
        `CHK("over at margin", 1'b1, alert_over)
        conv(10'h1ef);
        `CHK("over cleared", 1'b0, alert_over)
    endtask : t_over
    task automatic t_under;
        conv(10'h03f);
        `CHK("under set", 1'b1, alert_under)
        conv(10'h050);
        `CHK("under at margin", 1'b1, alert_under)
        conv(10'h051);
        `CHK("under cleared", 1'b0, alert_under)
        get(8'h06, w);
        `CHK("lowest", 16'h00fc, w)
        get(8'h07, w);
        `CHK("highest", 16'h0a94, w)
    endtask : t_under
    task automatic t_hold;
        set8(8'h02, 8'h18);
        conv(10'h201);
        conv(10'h03f);
        conv(10'h100);
        `CHK("over held", 1'b1, alert_over)
        `CHK("under held", 1'b1, alert_under)
        set8(8'h01, 8'h00);
        `CHK("zero write", 1'b1, alert_over)
        set8(8'h01, 8'h02);
        `CHK("over w1c", 1'b0, alert_over)
        `CHK("under kept", 1'b1, alert_under)
        set8(8'h01, 8'h01);
        `CHK("under w1c", 1'b0, alert_under)
        set8(8'h02, 8'h10);
        conv(10'h201);
        get(8'h00, w);
        `CHK("summary off", 16'h0804, w)
    endtask : t_hold
    task automatic wrap_up;
        `CHK("hangs", 0, m.n_hang)
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge link_clk);
        link_rst <= 1'b0;
        t_reset;
        t_result;
        t_ptr;
        t_over;
        t_under;
        t_hold;
        wrap_up;
    end
    initial begin
        #100000;
        n_mismatch++;
        wrap_up;
    end
endmodule : aprar_regs_tb
`default_nettype wire
